// >>> design/l2f_regs.vh
`ifndef L2F_REGS_VH
`define L2F_REGS_VH

// apb register byte offsets
`define L2F_A_CTRL 8'h00
`define L2F_A_AGE 8'h04
`define L2F_A_LEARN 8'h08
`define L2F_A_IPEN 8'h0c
`define L2F_A_ARPEN 8'h10
`define L2F_A_LIMIT 8'h14
`define L2F_A_INDEX 8'h18
`define L2F_A_DATA0 8'h1c
`define L2F_A_DATA1 8'h20
`define L2F_A_DATA2 8'h24
`define L2F_A_DATA3 8'h28
`define L2F_A_CMD 8'h2c
`define L2F_A_STATUS 8'h30

// control register fields
`define L2F_CTRL_AGE_EN 0
`define L2F_CTRL_IPSG 1
`define L2F_CTRL_ARP 2
`define L2F_CTRL_RST 3'h1

// age time in seconds
`define L2F_AGE_RST 24'h00012c
`define L2F_AGE_MIN 24'h00000a
`define L2F_AGE_MAX 24'h989680

// learning modes
`define L2F_LM_AUTO 2'h0
`define L2F_LM_OFF 2'h1
`define L2F_LM_SECURE 2'h2

// dynamic client limit code meaning unlimited
`define L2F_LIM_UNL 2'h3

// table select in index register
`define L2F_T_STATIC 2'h0
`define L2F_T_DYN 2'h1
`define L2F_T_IPB 2'h2
`define L2F_T_ARPB 2'h3
`define L2F_IDX_TSEL 14

// commands
`define L2F_CMD_WR 2'h1
`define L2F_CMD_RD 2'h2

// data2 fields
`define L2F_D2_VALID 31
`define L2F_D2_STATIC 30

// timing
`define L2F_SEC_NS 1000000000
`define L2F_CLK_NS 100

`endif

// >>> design/l2f_core.v
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "l2f_regs.vh"

module l2f_core #(
    parameter [31:0] P_TICK_CYCLES = `L2F_SEC_NS / `L2F_CLK_NS
) (
    input wire i_clock,
    input wire i_rstn,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr,
    input wire i_frm_valid,
    input wire [3:0] i_frm_port,
    input wire [11:0] i_frm_vlan,
    input wire [47:0] i_destination_mac,
    input wire [47:0] i_source_mac,
    input wire [9:0] i_vlan_members,
    input wire i_frm_is_ip,
    input wire [31:0] i_frm_src_ip,
    input wire i_frm_is_arp,
    input wire i_frm_arp_op_ok,
    input wire [47:0] i_frm_arp_sender_mac,
    input wire [31:0] i_frm_arp_sender_ip,
    input wire i_frm_snoop_hit,
    input wire [9:0] i_mode_owned,
    input wire [19:0] i_owner_mode,
    input wire i_snoop_add,
    input wire i_snoop_del,
    input wire [3:0] i_snoop_port,
    output wire o_snoop_add_ok,
    output reg o_fwd_valid,
    output reg [9:0] o_fwd_ports,
    output reg o_fwd_drop,
    output reg [2:0] o_drop_cause
);

localparam NDYN = 8192;
localparam NST = 64;
localparam NB = 16;

function [12:0] l2f_hash;
    input [11:0] v;
    input [47:0] m;
    begin
        l2f_hash = m[12:0] ^ m[25:13] ^ m[38:26] ^ {m[47:39], v[3:0]} ^ {5'h00, v[11:4]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage
reg dyn_v [0:NDYN-1];
reg dyn_hit [0:NDYN-1];
reg [11:0] dyn_vlan [0:NDYN-1];
reg [47:0] dyn_mac [0:NDYN-1];
reg [3:0] dyn_port [0:NDYN-1];
reg st_v [0:NST-1];
reg [11:0] st_vlan [0:NST-1];
reg [47:0] st_mac [0:NST-1];
reg [9:0] st_mem [0:NST-1];
reg ipb_v [0:NB-1];
reg [3:0] ipb_port [0:NB-1];
reg [11:0] ipb_vlan [0:NB-1];
reg [47:0] ipb_mac [0:NB-1];
reg [31:0] ipb_ip [0:NB-1];
reg arb_v [0:NB-1];
reg [3:0] arb_port [0:NB-1];
reg [11:0] arb_vlan [0:NB-1];
reg [47:0] arb_mac [0:NB-1];
reg [31:0] arb_ip [0:NB-1];

reg [2:0] ctrl_q;
reg [23:0] age_q;
reg [19:0] mode_q;
reg [9:0] ipen_q;
reg [9:0] arpen_q;
reg [19:0] lim_q;
reg [15:0] idx_q;
reg [31:0] d0_q, d1_q, d2_q, d3_q;
reg [19:0] cnt_q;
reg [23:0] sec_cnt_q;
reg [23:0] age_cnt_q;
reg sweep_q;
reg [12:0] sw_idx_q;
integer i, n;

////////////////////////////////////////////////////////////////////////////////
// lookup and filtering
wire acc = i_psel & i_penable;
wire wr = acc & i_pwrite;
wire [12:0] d_idx = l2f_hash(i_frm_vlan, i_destination_mac);
wire [12:0] s_idx = l2f_hash(i_frm_vlan, i_source_mac);
wire [4:0] pbase = {i_frm_port, 1'b0};
wire [9:0] in_bit = 10'h001 << i_frm_port;
reg [19:0] eff_mode;
reg st_dhit, st_shit, ip_hit, arp_hit;
reg [9:0] st_dmem;

always @* begin
    for (n = 0; n < 10; n = n + 1) begin
        eff_mode[2*n +: 2] = i_mode_owned[n] ? i_owner_mode[2*n +: 2] : mode_q[2*n +: 2];
    end
    st_dhit = 1'b0;
    st_shit = 1'b0;
    st_dmem = 10'h000;
    ip_hit = 1'b0;
    arp_hit = 1'b0;
    for (n = 0; n < NST; n = n + 1) begin
        if (st_v[n] && st_vlan[n] == i_frm_vlan && st_mac[n] == i_destination_mac) begin
            st_dhit = 1'b1;
            st_dmem = st_dmem | st_mem[n];
        end
        if (st_v[n] && st_vlan[n] == i_frm_vlan && st_mac[n] == i_source_mac) begin
            st_shit = 1'b1;
        end
    end
    for (n = 0; n < NB; n = n + 1) begin
        if (ipb_v[n] && ipb_port[n] == i_frm_port && ipb_vlan[n] == i_frm_vlan &&
            ipb_ip[n] == i_frm_src_ip && ipb_mac[n] == i_source_mac) begin
            ip_hit = 1'b1;
        end
        if (arb_v[n] && arb_port[n] == i_frm_port && arb_vlan[n] == i_frm_vlan &&
            arb_mac[n] == i_frm_arp_sender_mac && arb_ip[n] == i_frm_arp_sender_ip) begin
            arp_hit = 1'b1;
        end
    end
end

wire [1:0] in_mode = eff_mode[pbase +: 2];
wire [1:0] in_lim = lim_q[pbase +: 2];
wire dyn_dhit = dyn_v[d_idx] && dyn_vlan[d_idx] == i_frm_vlan && dyn_mac[d_idx] == i_destination_mac;
wire [9:0] dyn_bit = 10'h001 << dyn_port[d_idx];
wire sec_drop = in_mode == `L2F_LM_SECURE && !st_shit;
wire ip_act = ctrl_q[`L2F_CTRL_IPSG] & ipen_q[i_frm_port];
// zero limit: static bindings only
wire ip_ok = ip_hit | (in_lim != 2'h0 & i_frm_snoop_hit);
wire ip_drop = i_frm_is_ip & ip_act & !ip_ok;
wire arp_act = ctrl_q[`L2F_CTRL_ARP] & arpen_q[i_frm_port];
wire arp_drop = i_frm_is_arp & arp_act & !(i_frm_arp_op_ok & (arp_hit | i_frm_snoop_hit));
// a learning frame (auto mode) wins the array port over the sweep
wire learn = i_frm_valid & in_mode == `L2F_LM_AUTO;

always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
        o_fwd_valid <= 1'b0;
        o_fwd_ports <= 10'h000;
        o_fwd_drop <= 1'b0;
        o_drop_cause <= 3'h0;
    end else begin
        o_fwd_valid <= i_frm_valid;
        o_fwd_drop <= i_frm_valid & (sec_drop | ip_drop | arp_drop);
        o_drop_cause <= {arp_drop, ip_drop, sec_drop};
        if (!i_frm_valid || sec_drop || ip_drop || arp_drop) begin
            o_fwd_ports <= 10'h000;
        end else if (st_dhit) begin
            o_fwd_ports <= st_dmem;
        end else if (dyn_dhit) begin
            o_fwd_ports <= dyn_bit;
        end else begin
            o_fwd_ports <= i_vlan_members & ~in_bit;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// dynamic table, aging
wire tick = sec_cnt_q == P_TICK_CYCLES[23:0] - 24'h000001;
wire cmd_wr = wr && i_paddr == `L2F_A_CMD && i_pwdata[1:0] == `L2F_CMD_WR;
wire cmd_rd = wr && i_paddr == `L2F_A_CMD && i_pwdata[1:0] == `L2F_CMD_RD;
wire [1:0] tsel = idx_q[`L2F_IDX_TSEL +: 2];
wire dyn_del = cmd_wr && tsel == `L2F_T_DYN;
wire sw_step = sweep_q & !learn & !dyn_del;

always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
        sec_cnt_q <= 24'h000000;
        age_cnt_q <= 24'h000000;
        sweep_q <= 1'b0;
        sw_idx_q <= 13'h0000;
        for (i = 0; i < NDYN; i = i + 1) begin
            dyn_v[i] <= 1'b0;
            dyn_hit[i] <= 1'b0;
        end
    end else begin
        sec_cnt_q <= tick ? 24'h000000 : sec_cnt_q + 24'h000001;
        if (!ctrl_q[`L2F_CTRL_AGE_EN]) begin
            age_cnt_q <= 24'h000000;
        end else if (tick) begin
            if (age_cnt_q >= age_q - 24'h000001) begin
                age_cnt_q <= 24'h000000;
                sweep_q <= 1'b1;
                sw_idx_q <= 13'h0000;
            end else begin
                age_cnt_q <= age_cnt_q + 24'h000001;
            end
        end
        if (learn) begin
            dyn_v[s_idx] <= 1'b1;
            dyn_hit[s_idx] <= 1'b1;
        end else if (dyn_del) begin
            dyn_v[idx_q[12:0]] <= 1'b0;
        end else if (sw_step) begin
            // a hit buys one more pass: removal takes one to two age times
            if (dyn_hit[sw_idx_q]) begin
                dyn_hit[sw_idx_q] <= 1'b0;
            end else if (ctrl_q[`L2F_CTRL_AGE_EN]) begin
                dyn_v[sw_idx_q] <= 1'b0;
            end
            sw_idx_q <= sw_idx_q + 13'h0001;
            if (sw_idx_q == 13'h1fff) begin
                sweep_q <= 1'b0;
            end
        end
    end
end

// a colliding address replaces the slot's occupant
always @(posedge i_clock) begin
    if (learn) begin
        dyn_vlan[s_idx] <= i_frm_vlan;
        dyn_mac[s_idx] <= i_source_mac;
        dyn_port[s_idx] <= i_frm_port;
    end
end

////////////////////////////////////////////////////////////////////////////////
// static tables, written by command
wire [5:0] sti = idx_q[5:0];
wire [3:0] bi = idx_q[3:0];
wire ipsg_on = wr && i_paddr == `L2F_A_CTRL && i_pwdata[`L2F_CTRL_IPSG] && !ctrl_q[`L2F_CTRL_IPSG];

always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
        for (i = 0; i < NST; i = i + 1) begin
            st_v[i] <= 1'b0;
        end
        for (i = 0; i < NB; i = i + 1) begin
            ipb_v[i] <= 1'b0;
            arb_v[i] <= 1'b0;
        end
    end else begin
        if (cmd_wr && tsel == `L2F_T_STATIC) begin
            st_v[sti] <= d2_q[`L2F_D2_VALID];
        end
        if (ipsg_on) begin
            for (i = 0; i < NB; i = i + 1) begin
                ipb_v[i] <= 1'b0;
            end
        end else if (cmd_wr && tsel == `L2F_T_IPB) begin
            ipb_v[bi] <= d2_q[`L2F_D2_VALID];
        end
        if (cmd_wr && tsel == `L2F_T_ARPB) begin
            arb_v[bi] <= d2_q[`L2F_D2_VALID];
        end
    end
end

always @(posedge i_clock) begin
    if (cmd_wr && tsel == `L2F_T_STATIC) begin
        st_vlan[sti] <= d1_q[27:16];
        st_mac[sti] <= {d1_q[15:0], d0_q};
        st_mem[sti] <= d2_q[9:0];
    end
    if (cmd_wr && tsel == `L2F_T_IPB) begin
        ipb_vlan[bi] <= d1_q[27:16];
        ipb_mac[bi] <= {d1_q[15:0], d0_q};
        ipb_port[bi] <= d2_q[3:0];
        ipb_ip[bi] <= d3_q;
    end
    if (cmd_wr && tsel == `L2F_T_ARPB) begin
        arb_vlan[bi] <= d1_q[27:16];
        arb_mac[bi] <= {d1_q[15:0], d0_q};
        arb_port[bi] <= d2_q[3:0];
        arb_ip[bi] <= d3_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// dynamic client limit
wire [4:0] sbase = {i_snoop_port, 1'b0};
wire [1:0] s_lim = lim_q[sbase +: 2];
wire [1:0] s_cnt = cnt_q[sbase +: 2];
assign o_snoop_add_ok = s_lim == `L2F_LIM_UNL || s_cnt < s_lim;

always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
        cnt_q <= 20'h00000;
    end else if (i_snoop_add && !i_snoop_del && o_snoop_add_ok && s_cnt != 2'h3) begin
        cnt_q[sbase +: 2] <= s_cnt + 2'h1;
    end else if (i_snoop_del && !i_snoop_add && s_cnt != 2'h0) begin
        cnt_q[sbase +: 2] <= s_cnt - 2'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: zero wait, read data latched in setup
assign o_pready = 1'b1;
reg [31:0] rd_d;
reg err_d;

always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (i_paddr == `L2F_A_CTRL) begin
        rd_d = {29'h00000000, ctrl_q};
    end else if (i_paddr == `L2F_A_AGE) begin
        rd_d = {8'h00, age_q};
    end else if (i_paddr == `L2F_A_LEARN) begin
        rd_d = {12'h000, eff_mode};
    end else if (i_paddr == `L2F_A_IPEN) begin
        rd_d = {22'h000000, ipen_q};
    end else if (i_paddr == `L2F_A_ARPEN) begin
        rd_d = {22'h000000, arpen_q};
    end else if (i_paddr == `L2F_A_LIMIT) begin
        rd_d = {12'h000, lim_q};
    end else if (i_paddr == `L2F_A_INDEX) begin
        rd_d = {16'h0000, idx_q};
    end else if (i_paddr == `L2F_A_DATA0) begin
        rd_d = d0_q;
    end else if (i_paddr == `L2F_A_DATA1) begin
        rd_d = d1_q;
    end else if (i_paddr == `L2F_A_DATA2) begin
        rd_d = d2_q;
    end else if (i_paddr == `L2F_A_DATA3) begin
        rd_d = d3_q;
    end else if (i_paddr == `L2F_A_CMD) begin
        rd_d = 32'h00000000;
    end else if (i_paddr == `L2F_A_STATUS) begin
        rd_d = {19'h00000, sw_idx_q[11:0], sweep_q};
    end else begin
        err_d = 1'b1;
    end
end

always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
        o_prdata <= 32'h00000000;
        o_pslverr <= 1'b0;
        ctrl_q <= `L2F_CTRL_RST;
        age_q <= `L2F_AGE_RST;
        mode_q <= 20'h00000;
        ipen_q <= 10'h000;
        arpen_q <= 10'h000;
        lim_q <= 20'hfffff;
        idx_q <= 16'h0000;
        d0_q <= 32'h00000000;
        d1_q <= 32'h00000000;
        d2_q <= 32'h00000000;
        d3_q <= 32'h00000000;
    end else begin
        if (i_psel && !i_penable) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rd_d;
            o_pslverr <= err_d;
        end
        if (wr) begin
            if (i_paddr == `L2F_A_CTRL) begin
                ctrl_q <= i_pwdata[2:0];
            end else if (i_paddr == `L2F_A_AGE) begin
                // out of range ages are ignored
                if (i_pwdata[31:24] == 8'h00 && i_pwdata[23:0] >= `L2F_AGE_MIN &&
                    i_pwdata[23:0] <= `L2F_AGE_MAX) begin
                    age_q <= i_pwdata[23:0];
                end
            end else if (i_paddr == `L2F_A_LEARN) begin
                for (i = 0; i < 10; i = i + 1) begin
                    if (!i_mode_owned[i]) begin
                        mode_q[2*i +: 2] <= i_pwdata[2*i +: 2];
                    end
                end
            end else if (i_paddr == `L2F_A_IPEN) begin
                ipen_q <= i_pwdata[9:0];
            end else if (i_paddr == `L2F_A_ARPEN) begin
                arpen_q <= i_pwdata[9:0];
            end else if (i_paddr == `L2F_A_LIMIT) begin
                lim_q <= i_pwdata[19:0];
            end else if (i_paddr == `L2F_A_INDEX) begin
                idx_q <= i_pwdata[15:0];
            end else if (i_paddr == `L2F_A_DATA0) begin
                d0_q <= i_pwdata;
            end else if (i_paddr == `L2F_A_DATA1) begin
                d1_q <= i_pwdata;
            end else if (i_paddr == `L2F_A_DATA2) begin
                d2_q <= i_pwdata;
            end else if (i_paddr == `L2F_A_DATA3) begin
                d3_q <= i_pwdata;
            end
        end
        if (cmd_rd) begin
            d3_q <= 32'h00000000;
            if (tsel == `L2F_T_STATIC) begin
                d0_q <= st_mac[sti][31:0];
                d1_q <= {4'h0, st_vlan[sti], st_mac[sti][47:32]};
                d2_q <= {st_v[sti], 1'b1, 20'h00000, st_mem[sti]};
            end else if (tsel == `L2F_T_DYN) begin
                d0_q <= dyn_mac[idx_q[12:0]][31:0];
                d1_q <= {4'h0, dyn_vlan[idx_q[12:0]], dyn_mac[idx_q[12:0]][47:32]};
                d2_q <= {dyn_v[idx_q[12:0]], 1'b0, 20'h00000, 10'h001 << dyn_port[idx_q[12:0]]};
            end else if (tsel == `L2F_T_IPB) begin
                d0_q <= ipb_mac[bi][31:0];
                d1_q <= {4'h0, ipb_vlan[bi], ipb_mac[bi][47:32]};
                d2_q <= {ipb_v[bi], 1'b1, 26'h0000000, ipb_port[bi]};
                d3_q <= ipb_ip[bi];
            end else begin
                d0_q <= arb_mac[bi][31:0];
                d1_q <= {4'h0, arb_vlan[bi], arb_mac[bi][47:32]};
                d2_q <= {arb_v[bi], 1'b1, 26'h0000000, arb_port[bi]};
                d3_q <= arb_ip[bi];
            end
        end
    end
end

endmodule

// >>> tb/l2f_core_monitor.sv
`timescale 1ns/100ps
module l2f_core_monitor (
    input wire i_clock,
    input wire i_rstn,
    input wire i_psel,
    input wire i_penable,
    input wire [7:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_frm_valid,
    input wire i_frm_is_ip,
    input wire i_frm_is_arp,
    input wire o_fwd_valid,
    input wire [9:0] o_fwd_ports,
    input wire o_fwd_drop,
    input wire [2:0] o_drop_cause
);
    default clocking mon_cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////////
    a_fwd_one_later: assert property (i_frm_valid |=> o_fwd_valid)
        else $error("no forward result");
    a_fwd_has_frame: assert property (o_fwd_valid |-> $past(i_frm_valid))
        else $error("result without frame");
    a_fwd_single_pulse: assert property (o_fwd_valid && !i_frm_valid |=> !o_fwd_valid)
        else $error("result held too long");
    a_drop_no_ports: assert property (o_fwd_valid && o_fwd_drop |-> o_fwd_ports == 10'h000)
        else $error("dropped frame has ports");
    a_drop_cause_match: assert property (o_fwd_valid |-> o_fwd_drop == (o_drop_cause != 3'h0))
        else $error("drop and cause disagree");
    a_ip_cause_src: assert property (o_fwd_valid && o_drop_cause[1] |-> $past(i_frm_is_ip))
        else $error("ip drop on non ip");
    a_arp_cause_src: assert property (o_fwd_valid && o_drop_cause[2] |-> $past(i_frm_is_arp))
        else $error("arp drop on non arp");
    a_unmapped_err: assert property (i_psel && !i_penable && i_paddr > 8'h30 |=> o_pslverr)
        else $error("no error on unmapped");
    a_mapped_ok: assert property (i_psel && !i_penable && i_paddr <= 8'h30 && i_paddr[1:0] == 2'h0
        |=> !o_pslverr)
        else $error("error on mapped");
    a_access_ready: assert property (i_psel && i_penable |-> o_pready)
        else $error("access phase stalled");
endmodule
bind l2f_core l2f_core_monitor mon_u (.i_clock, .i_rstn, .i_psel, .i_penable, .i_paddr, .o_pready,
    .o_pslverr, .i_frm_valid, .i_frm_is_ip, .i_frm_is_arp, .o_fwd_valid, .o_fwd_ports, .o_fwd_drop,
    .o_drop_cause);

// >>> tb/l2f_port_model.sv
`timescale 1ns/100ps
module l2f_port_model (
    input wire i_clock,
    input wire i_fwd_valid,
    input wire [9:0] i_fwd_ports,
    input wire i_fwd_drop,
    input wire [2:0] i_drop_cause,
    input wire i_snoop_add_ok,
    output reg o_frm_valid,
    output reg [3:0] o_frm_port,
    output reg [11:0] o_frm_vlan,
    output reg [9:0] o_vlan_members,
    output reg [47:0] o_destination_mac,
    output reg [47:0] o_source_mac,
    output reg [31:0] o_ip,
    output reg o_frm_is_ip,
    output reg o_frm_is_arp,
    output reg o_frm_arp_op_ok,
    output reg o_frm_snoop_hit,
    output reg o_snoop_add,
    output reg [3:0] o_snoop_port
);
    reg [14:0] res;
    initial begin
        {o_frm_valid, o_frm_port, o_frm_vlan, o_vlan_members, o_destination_mac, o_source_mac, o_ip} = 0;
        {o_frm_is_ip, o_frm_is_arp, o_frm_arp_op_ok, o_frm_snoop_hit, o_snoop_add, o_snoop_port} = 0;
        res = 15'h0;
    end
    ////////////////////////////////////////////////////////////////
    // k: {bad arp opcode, arp, ip, snoop hit}
    task frame(input [3:0] p, input [47:0] d, input [47:0] s, input [3:0] k);
        begin
            @(posedge i_clock);
            o_frm_valid <= 1'b1;
            o_frm_port <= p;
            {o_frm_vlan, o_vlan_members} <= {12'h001, 10'h3ff};
            {o_destination_mac, o_source_mac, o_ip} <= {d, s, 32'h0a000001};
            {o_frm_arp_op_ok, o_frm_is_arp, o_frm_is_ip, o_frm_snoop_hit} <= {~k[3], k[2:0]};
            @(posedge i_clock);
            o_frm_valid <= 1'b0;
            // stale fields are inverted so nothing matches by luck
            {o_frm_vlan, o_vlan_members} <= ~{12'h001, 10'h3ff};
            {o_destination_mac, o_source_mac, o_ip} <= ~{d, s, 32'h0a000001};
            @(negedge i_clock);
            res = {i_fwd_valid, i_fwd_drop, i_drop_cause, i_fwd_ports};
        end
    endtask
    task snoop(input [3:0] p, output ok);
        begin
            @(posedge i_clock);
            o_snoop_add <= 1'b1;
            o_snoop_port <= p;
            @(negedge i_clock);
            ok = i_snoop_add_ok;
            @(posedge i_clock);
            o_snoop_add <= 1'b0;
            o_snoop_port <= ~p;
        end
    endtask
endmodule

// >>> tb/l2f_core_tb.sv
`timescale 1ns/100ps
`include "l2f_regs.vh"
module l2f_core_tb;
    localparam [47:0] MA = 48'h0200000000a1, MB = 48'h0200000000b2, MC = 48'h0200000000c3;
    localparam [47:0] ME = 48'h0200000000e4, MF = 48'h0200000000f5, MG = 48'h020000000016;
    localparam [47:0] MH = 48'h020000000027, MJ = 48'h020000000038, MS = 48'h020000000049;
    localparam [47:0] MX = 48'h02000000005a;
    reg i_clock = 1'b0;
    reg i_rstn = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rdat;
    reg rerr;
    reg [9:0] own = 10'h000;
    integer errors = 0, cmp_count = 0;
    wire pready, pslverr, fv, ip_f, arp_f, op_ok, hit, s_add, s_ok, ov, od;
    wire [31:0] prdata, ipv;
    wire [3:0] fport, s_port;
    wire [11:0] fvlan;
    wire [9:0] memb, oports;
    wire [47:0] dst_mac, src_mac;
    wire [2:0] ocause;
    always #50 i_clock = ~i_clock;
    l2f_core #(.P_TICK_CYCLES(32'd1000)) dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_frm_valid(fv), .i_frm_port(fport), .i_frm_vlan(fvlan),
        .i_destination_mac(dst_mac), .i_source_mac(src_mac), .i_vlan_members(memb), .i_frm_is_ip(ip_f),
        .i_frm_src_ip(ipv), .i_frm_is_arp(arp_f), .i_frm_arp_op_ok(op_ok), .i_frm_arp_sender_mac(src_mac),
        .i_frm_arp_sender_ip(ipv), .i_frm_snoop_hit(hit), .i_mode_owned(own), .i_owner_mode(20'h55555),
        .i_snoop_add(s_add), .i_snoop_del(1'b0), .i_snoop_port(s_port), .o_snoop_add_ok(s_ok),
        .o_fwd_valid(ov), .o_fwd_ports(oports), .o_fwd_drop(od), .o_drop_cause(ocause));
    l2f_port_model mdl_u (.i_clock(i_clock), .i_fwd_valid(ov), .i_fwd_ports(oports), .i_fwd_drop(od),
        .i_drop_cause(ocause), .i_snoop_add_ok(s_ok), .o_frm_valid(fv), .o_frm_port(fport), .o_frm_vlan(fvlan),
        .o_vlan_members(memb), .o_destination_mac(dst_mac), .o_source_mac(src_mac), .o_ip(ipv),
        .o_frm_is_ip(ip_f), .o_frm_is_arp(arp_f), .o_frm_arp_op_ok(op_ok), .o_frm_snoop_hit(hit),
        .o_snoop_add(s_add), .o_snoop_port(s_port));
    ////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge i_clock);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge i_clock);
            penable <= 1'b1;
            @(posedge i_clock);
            while (pready !== 1'b1)
                @(posedge i_clock);
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rc(input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rdat, e);
        end
    endtask
    task ent(input [1:0] t, input [13:0] i, input [47:0] m, input [31:0] d2);
        begin
            wr(`L2F_A_INDEX, {16'h0, t, i});
            wr(`L2F_A_DATA0, m[31:0]);
            wr(`L2F_A_DATA1, {4'h0, 12'h001, m[47:32]});
            wr(`L2F_A_DATA2, d2);
            wr(`L2F_A_DATA3, 32'h0a000001);
            wr(`L2F_A_CMD, {30'h0, `L2F_CMD_WR});
        end
    endtask
    task fp(input [3:0] p, input [47:0] d, input [47:0] s, input [3:0] k, input [9:0] e);
        begin
            mdl_u.frame(p, d, s, k);
            chk({17'h0, mdl_u.res}, {17'h0, 5'h10, e});
        end
    endtask
    task fd(input [3:0] p, input [47:0] d, input [47:0] s, input [3:0] k, input [2:0] c);
        begin
            mdl_u.frame(p, d, s, k);
            chk({17'h0, mdl_u.res}, {17'h0, 2'h3, c, 10'h000});
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_regs;
        begin
            rc(`L2F_A_CTRL, 32'h1);
            rc(`L2F_A_AGE, 32'h12c);
            rc(`L2F_A_LIMIT, 32'hfffff);
            rc(`L2F_A_LEARN, 32'h0);
            apb(1'b0, 8'h40, 32'h0);
            chk(rerr, 1);
            wr(`L2F_A_AGE, 32'h9);
            rc(`L2F_A_AGE, 32'h12c);
            wr(`L2F_A_AGE, 32'h989681);
            rc(`L2F_A_AGE, 32'h12c);
            wr(`L2F_A_AGE, 32'h989680);
            rc(`L2F_A_AGE, 32'h989680);
            wr(`L2F_A_AGE, 32'ha);
            rc(`L2F_A_AGE, 32'ha);
            $display("register test done");
        end
    endtask
    task t_learn;
        begin
            fp(2, MX, MA, 0, 10'h3fb);
            fp(5, MA, MB, 0, 10'h004);
            fp(2, MB, MA, 0, 10'h020);
            wr(`L2F_A_LEARN, 32'h40);
            fp(3, MA, MC, 0, 10'h004);
            fp(5, MC, MB, 0, 10'h3df);
            own <= 10'h008;
            wr(`L2F_A_LEARN, 32'h0);
            rc(`L2F_A_LEARN, 32'h40);
            $display("learning test done");
        end
    endtask
    task t_static;
        begin
            ent(`L2F_T_STATIC, 14'h3f, MS, {2'h3, 20'h0, 10'h210});
            fp(0, MS, MG, 0, 10'h210);
            wr(`L2F_A_CMD, {30'h0, `L2F_CMD_RD});
            rc(`L2F_A_DATA2, {2'h3, 20'h0, 10'h210});
            ent(`L2F_T_STATIC, 14'h3f, MS, {2'h3, 20'h0, 10'h081});
            fp(0, MS, MG, 0, 10'h081);
            wr(`L2F_A_LEARN, 32'h2000);
            fd(6, MA, ME, 0, 3'h1);
            fp(6, MA, MS, 0, 10'h004);
            fp(5, ME, MB, 0, 10'h3df);
            wr(`L2F_A_LEARN, 32'h0);
            $display("static test done");
        end
    endtask
    task t_ipsg;
        begin
            wr(`L2F_A_IPEN, 32'h80);
            ent(`L2F_T_IPB, 14'h0, MF, {1'b1, 27'h0, 4'h7});
            fp(7, MA, MF, 4'h2, 10'h004);
            wr(`L2F_A_CTRL, 32'h3);
            wr(`L2F_A_LIMIT, 32'hf3fff);
            fd(7, MA, MF, 4'h2, 3'h2);
            ent(`L2F_T_IPB, 14'h0, MF, {1'b1, 27'h0, 4'h7});
            fp(7, MA, MF, 4'h2, 10'h004);
            fd(7, MA, MG, 4'h3, 3'h2);
            wr(`L2F_A_LIMIT, 32'hfffff);
            fp(7, MA, MG, 4'h3, 10'h004);
            fd(7, MA, MG, 4'h2, 3'h2);
            fp(8, MA, MG, 4'h2, 10'h004);
            wr(`L2F_A_CTRL, 32'h1);
            $display("ip test done");
        end
    endtask
    task t_arp;
        begin
            wr(`L2F_A_ARPEN, 32'h100);
            wr(`L2F_A_CTRL, 32'h5);
            fd(8, MA, MF, 4'h4, 3'h4);
            ent(`L2F_T_ARPB, 14'h0, MF, {1'b1, 27'h0, 4'h8});
            fp(8, MA, MF, 4'h4, 10'h004);
            fd(8, MA, MF, 4'hc, 3'h4);
            fp(9, MA, MF, 4'hc, 10'h004);
            wr(`L2F_A_CTRL, 32'h1);
            $display("arp test done");
        end
    endtask
    // age 10 s is 10000 cycles; removal takes one to two age times
    task t_age;
        begin
            wr(`L2F_A_CTRL, 32'h0);
            fp(4, MX, MH, 0, 10'h3ef);
            repeat (20500) @(posedge i_clock);
            fp(5, MH, MB, 0, 10'h010);
            wr(`L2F_A_CTRL, 32'h1);
            fp(1, MX, MJ, 0, 10'h3fd);
            repeat (3) begin
                repeat (8000) @(posedge i_clock);
                fp(1, MX, MJ, 0, 10'h3fd);
            end
            fp(5, MJ, MB, 0, 10'h002);
            fp(5, MH, MB, 0, 10'h3df);
            $display("aging test done");
        end
    endtask
    task t_snoop;
        reg ok;
        integer k;
        begin
            wr(`L2F_A_LIMIT, 32'hfff27);
            for (k = 0; k < 9; k = k + 1) begin
                mdl_u.snoop(36'h444322211 >> (4 * k), ok);
                chk(ok, (9'h1cd >> k) & 9'h1);
            end
            $display("limit test done");
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_regs;
        t_learn;
        t_static;
        t_ipsg;
        t_arp;
        t_age;
        t_snoop;
        final_report;
    end
    initial begin
        repeat (60000) @(posedge i_clock);
        errors = errors + 1;
        final_report;
    end
endmodule
